// ### src/bmseq_regs.vh
// constants for the boot mode sequencer
`ifndef BMSEQ_REGS_VH
`define BMSEQ_REGS_VH
`define BMSEQ_MODE_NONE   2'h0
`define BMSEQ_MODE_HOST   2'h1
`define BMSEQ_MODE_ROM    2'h3
`define BMSEQ_CE1_BASE    32'h90000000
`define BMSEQ_CE1_TOP_NIB 4'h9
`define BMSEQ_COPY_BYTES  32'd1024
`define BMSEQ_BYTE_W      8
`define BMSEQ_WORD_W      32
`define BMSEQ_LANE_LAST   2'h3
`define BMSEQ_CPU_START   32'h00000000
`define BMSEQ_ONE_ADDR    32'h00000001
`define BMSEQ_WORD_STEP   32'h00000004
`define BMSEQ_SETTLE_LAST 3'h4
`endif

// ### src/bmseq_sync3.v
// three-stage synchroniser with agreement filter for strap pins
`timescale 1ns/10ps
module bmseq_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  // s1 feeds only s2; the output moves only when s2 and s3 agree
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end
endmodule // bmseq_sync3

// ### src/bmseq_pack.v
// little/big endian byte-to-word packer for the rom copy
`timescale 1ns/10ps
`include "bmseq_regs.vh"
module bmseq_pack (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      clr,
  input  wire                      big_endian,
  input  wire                      byte_vld,
  input  wire [`BMSEQ_BYTE_W-1:0]  byte_in,
  output reg                       word_vld,
  output reg  [`BMSEQ_WORD_W-1:0]  word_out
);
  reg [1:0]                 lane_r;
  reg [`BMSEQ_WORD_W-1:0]   acc_r;
  wire [`BMSEQ_WORD_W-1:0]  acc_nxt;
  // first byte is lowest address; it lands in the low lane when little endian
  assign acc_nxt = big_endian ? {acc_r[`BMSEQ_WORD_W-`BMSEQ_BYTE_W-1:0], byte_in}
                              : {byte_in, acc_r[`BMSEQ_WORD_W-1:`BMSEQ_BYTE_W]};
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lane_r   <= 2'h0;
      acc_r    <= {`BMSEQ_WORD_W{1'b0}};
      word_vld <= 1'b0;
      word_out <= {`BMSEQ_WORD_W{1'b0}};
    end
    else
    begin
      word_vld <= 1'b0;
      if (clr)
        lane_r <= 2'h0;
      else if (byte_vld)
      begin
        acc_r  <= acc_nxt;
        lane_r <= lane_r + 2'h1;
        if (lane_r == `BMSEQ_LANE_LAST)
        begin
          word_vld <= 1'b1;
          word_out <= acc_nxt;
        end
      end
    end
  end
endmodule // bmseq_pack

// ### src/bmseq_top.v
// boot mode sequencer: reset hold, host boot, rom boot copy, no boot
// Functional notes
// - while reset is held, all state takes its reset value
// - after release exactly one of host, rom or no boot is followed
// - host boot keeps the cpu stalled while the rest leaves reset
// - host boot path is the parallel host port if strap 0, pci if 1
// - that bit set in host boot releases the cpu, fetch at address 0
// - the boot-ending interrupt is not latched as pending for the cpu
// - the bit releases the stall only in host boot mode
// - during the stall the host may write and read all memory
// - cpu clears the bit after release; until then no new interrupt
// - rom boot copies 1K byte from chip enable space one to address 0
// - rom bytes are packed four to a 32-bit word before writing
// - after the copy completes the cpu is released at address 0
// - no boot starts the cpu at address 0 with no copy
// - chip enable space one decodes as 256M at 9000_0000
`timescale 1ns/10ps
`include "bmseq_regs.vh"
module bmseq_top #(
  parameter COPY_BYTES = `BMSEQ_COPY_BYTES
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire [1:0]  BOOT_MODE_PIN,
  input  wire        PCI_SEL_PIN,
  input  wire        BIG_ENDIAN_PIN,
  input  wire        HOST_INT_SET,
  input  wire        CPU_INT_CLEAR,
  input  wire        ROM_BYTE_VLD,
  input  wire [7:0]  ROM_BYTE,
  input  wire        MEM_WR_READY,
  output reg         CPU_STALL,
  output reg  [31:0] CPU_START_ADDR,
  output reg         PERIPH_RESET,
  output reg         HOST_PORT_EN,
  output reg         PCI_BOOT_EN,
  output reg         HOST_MEM_ACCESS_EN,
  output reg         HOST_INT_BIT,
  output reg         CPU_INT_PENDING,
  output reg         ROM_RD_REQ,
  output reg  [31:0] ROM_RD_ADDR,
  output reg         ROM_RD_CE1,
  output reg         MEM_WR_VLD,
  output reg  [31:0] MEM_WR_ADDR,
  output reg  [31:0] MEM_WR_DATA,
  output reg         BOOT_DONE
);
  localparam [5:0] ST_RESET = 6'h01;
  localparam [5:0] ST_LATCH = 6'h02;
  localparam [5:0] ST_HOST  = 6'h04;
  localparam [5:0] ST_COPY  = 6'h08;
  localparam [5:0] ST_FLUSH = 6'h10;
  localparam [5:0] ST_RUN   = 6'h20;

  wire [1:0]  mode_s;
  wire        pci_s;
  wire        endian_s;
  wire        word_vld;
  wire [31:0] word_out;

  reg [5:0]   state_r;
  reg [1:0]   mode_r;
  reg         pci_r;
  reg         endian_r;
  reg [31:0]  rd_cnt_r;
  reg [31:0]  wr_addr_r;
  reg         wr_pend_r;
  reg [31:0]  wr_data_r;
  reg [2:0]   settle_r;

  // chip enable space one window test, top nibble selects the 256M space
  function is_ce1;
    input [31:0] a;
    begin
      is_ce1 = (a[31:28] == `BMSEQ_CE1_TOP_NIB);
    end
  endfunction

  bmseq_sync3 #(.W(4)) u_sync (
    .clk  (REF_CLK),
    .rst  (RST),
    .din  ({BOOT_MODE_PIN, PCI_SEL_PIN, BIG_ENDIAN_PIN}),
    .dout ({mode_s, pci_s, endian_s})
  );

  bmseq_pack u_pack (
    .clk        (REF_CLK),
    .rst        (RST),
    .clr        (state_r != ST_COPY),
    .big_endian (endian_r),
    .byte_vld   (ROM_BYTE_VLD && ROM_RD_REQ),
    .byte_in    (ROM_BYTE),
    .word_vld   (word_vld),
    .word_out   (word_out)
  );

  // straps need the synchroniser to fill after release before capture
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_r            <= ST_RESET;
      mode_r             <= `BMSEQ_MODE_NONE;
      pci_r              <= 1'b0;
      endian_r           <= 1'b0;
      settle_r           <= 3'h0;
      rd_cnt_r           <= 32'h0;
      wr_addr_r          <= `BMSEQ_CPU_START;
      wr_pend_r          <= 1'b0;
      wr_data_r          <= 32'h0;
      CPU_STALL          <= 1'b1;
      CPU_START_ADDR     <= `BMSEQ_CPU_START;
      PERIPH_RESET       <= 1'b1;
      HOST_PORT_EN       <= 1'b0;
      PCI_BOOT_EN        <= 1'b0;
      HOST_MEM_ACCESS_EN <= 1'b0;
      HOST_INT_BIT       <= 1'b0;
      CPU_INT_PENDING    <= 1'b0;
      ROM_RD_REQ         <= 1'b0;
      ROM_RD_ADDR        <= `BMSEQ_CE1_BASE;
      ROM_RD_CE1         <= 1'b0;
      MEM_WR_VLD         <= 1'b0;
      MEM_WR_ADDR        <= `BMSEQ_CPU_START;
      MEM_WR_DATA        <= 32'h0;
      BOOT_DONE          <= 1'b0;
    end
    else
    begin
      // interrupt bit: set wins over clear; clear only acts once the cpu runs
      if (HOST_INT_SET && !HOST_INT_BIT)
        HOST_INT_BIT <= 1'b1;
      else if (CPU_INT_CLEAR && state_r == ST_RUN && !HOST_INT_SET)
        HOST_INT_BIT <= 1'b0;
      // only a new set seen while the cpu runs reaches it as pending
      if (HOST_INT_SET && !HOST_INT_BIT && state_r == ST_RUN)
        CPU_INT_PENDING <= 1'b1;
      else if (CPU_INT_CLEAR)
        CPU_INT_PENDING <= 1'b0;
      case (state_r)
        ST_RESET:
        begin
          settle_r <= settle_r + 3'h1;
          if (settle_r == `BMSEQ_SETTLE_LAST)
            state_r <= ST_LATCH;
        end
        ST_LATCH:
        begin
          mode_r       <= mode_s;
          pci_r        <= pci_s;
          endian_r     <= endian_s;
          PERIPH_RESET <= 1'b0;
          if (mode_s == `BMSEQ_MODE_HOST)
          begin
            state_r            <= ST_HOST;
            HOST_PORT_EN       <= !pci_s;
            PCI_BOOT_EN        <= pci_s;
            HOST_MEM_ACCESS_EN <= 1'b1;
          end
          else if (mode_s == `BMSEQ_MODE_ROM)
          begin
            state_r     <= ST_COPY;
            ROM_RD_REQ  <= 1'b1;
            ROM_RD_ADDR <= `BMSEQ_CE1_BASE;
            ROM_RD_CE1  <= is_ce1(`BMSEQ_CE1_BASE);
            rd_cnt_r    <= 32'h0;
          end
          else
          begin
            state_r        <= ST_RUN;
            CPU_STALL      <= 1'b0;
            CPU_START_ADDR <= `BMSEQ_CPU_START;
            BOOT_DONE      <= 1'b1;
          end
        end
        ST_HOST:
        begin
          // the mode check keeps the bit from releasing any other boot
          if (HOST_INT_SET && !HOST_INT_BIT && mode_r == `BMSEQ_MODE_HOST)
          begin
            state_r        <= ST_RUN;
            CPU_STALL      <= 1'b0;
            CPU_START_ADDR <= `BMSEQ_CPU_START;
            BOOT_DONE      <= 1'b1;
          end
        end
        ST_COPY:
        begin
          // one byte read per accepted byte; reads go on while a word waits
          if (ROM_BYTE_VLD && ROM_RD_REQ)
          begin
            rd_cnt_r    <= rd_cnt_r + `BMSEQ_ONE_ADDR;
            ROM_RD_ADDR <= ROM_RD_ADDR + `BMSEQ_ONE_ADDR;
            ROM_RD_CE1  <= is_ce1(ROM_RD_ADDR + `BMSEQ_ONE_ADDR);
            if (rd_cnt_r == COPY_BYTES - `BMSEQ_ONE_ADDR)
            begin
              ROM_RD_REQ <= 1'b0;
              state_r    <= ST_FLUSH;
            end
          end
          if (word_vld && !wr_pend_r)
          begin
            wr_pend_r <= 1'b1;
            wr_data_r <= word_out;
          end
        end
        ST_FLUSH:
        begin
          if (word_vld)
          begin
            wr_pend_r <= 1'b1;
            wr_data_r <= word_out;
          end
          else if (!wr_pend_r && !MEM_WR_VLD)
          begin
            state_r        <= ST_RUN;
            CPU_STALL      <= 1'b0;
            CPU_START_ADDR <= `BMSEQ_CPU_START;
            BOOT_DONE      <= 1'b1;
          end
        end
        ST_RUN:
        begin
          state_r <= ST_RUN;
        end
        default:
        begin
          state_r <= ST_RESET;
        end
      endcase
      // word writer toward address 0 upward
      if (MEM_WR_VLD && MEM_WR_READY)
      begin
        MEM_WR_VLD <= 1'b0;
        wr_addr_r  <= wr_addr_r + `BMSEQ_WORD_STEP;
      end
      else if (wr_pend_r && !MEM_WR_VLD)
      begin
        MEM_WR_VLD  <= 1'b1;
        MEM_WR_ADDR <= wr_addr_r;
        MEM_WR_DATA <= wr_data_r;
        wr_pend_r   <= 1'b0;
      end
    end
  end
endmodule // bmseq_top

// ### verif/bmseq_sva.sv
// assertion checker on the boot mode sequencer ports
`timescale 1ns/10ps
module bmseq_sva #(
  parameter COPY_BYTES = 1024
) (
  input wire        REF_CLK,
  input wire        RST,
  input wire        HOST_INT_SET,
  input wire        CPU_INT_CLEAR,
  input wire        MEM_WR_READY,
  input wire        CPU_STALL,
  input wire [31:0] CPU_START_ADDR,
  input wire        PERIPH_RESET,
  input wire        HOST_PORT_EN,
  input wire        PCI_BOOT_EN,
  input wire        HOST_MEM_ACCESS_EN,
  input wire        HOST_INT_BIT,
  input wire        CPU_INT_PENDING,
  input wire        ROM_RD_REQ,
  input wire [31:0] ROM_RD_ADDR,
  input wire        ROM_RD_CE1,
  input wire        MEM_WR_VLD,
  input wire [31:0] MEM_WR_ADDR,
  input wire [31:0] MEM_WR_DATA,
  input wire        BOOT_DONE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_host_set; HOST_MEM_ACCESS_EN && CPU_STALL && HOST_INT_SET; endsequence
  sequence s_release; ##[1:2] !CPU_STALL; endsequence
  // sampled during reset on purpose, so no disable here
  property p_rst; disable iff (1'b0)
    RST && $past(RST) |-> CPU_STALL && PERIPH_RESET && !BOOT_DONE && !ROM_RD_REQ
    && !MEM_WR_VLD; endproperty
  property p_start; CPU_START_ADDR == 32'h0; endproperty
  property p_host; s_host_set |-> s_release; endproperty
  property p_pend; CPU_STALL |-> !CPU_INT_PENDING; endproperty
  property p_copy; ROM_RD_REQ || MEM_WR_VLD |-> CPU_STALL; endproperty
  property p_ce1; ROM_RD_REQ |-> ROM_RD_ADDR[31:28] == 4'h9 && ROM_RD_CE1
    && ROM_RD_ADDR[27:0] < COPY_BYTES; endproperty
  property p_path; !PERIPH_RESET |-> !(HOST_PORT_EN && PCI_BOOT_EN)
    ##1 $stable({HOST_PORT_EN, PCI_BOOT_EN}); endproperty
  property p_hold; MEM_WR_VLD && !MEM_WR_READY |=> MEM_WR_VLD
    && $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA); endproperty
  property p_done; BOOT_DONE |-> !CPU_STALL && !PERIPH_RESET; endproperty
  property p_clr; HOST_INT_BIT && !CPU_STALL && CPU_INT_CLEAR && !HOST_INT_SET
    |-> ##[1:2] !HOST_INT_BIT; endproperty
  property p_perif; HOST_MEM_ACCESS_EN |-> !PERIPH_RESET; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_start: assert property (p_start) else $error("start address");
  a_host: assert property (p_host) else $error("host release late");
  a_pend: assert property (p_pend) else $error("pending while stalled");
  a_copy: assert property (p_copy) else $error("cpu ran during copy");
  a_ce1: assert property (p_ce1) else $error("rom address outside window");
  a_path: assert property (p_path) else $error("boot path changed");
  a_hold: assert property (p_hold) else $error("write not held");
  a_done: assert property (p_done) else $error("done while stalled");
  a_clr: assert property (p_clr) else $error("bit not cleared");
  a_perif: assert property (p_perif) else $error("rest held in host boot");
endmodule // bmseq_sva
bind bmseq_top bmseq_sva #(.COPY_BYTES(COPY_BYTES)) u_bmseq_sva (.*);

// ### verif/bmseq_rom_model.sv
// byte rom and word memory model at the far side of the boot copy
`timescale 1ns/10ps
module bmseq_rom_model (
  input  wire        clk,
  input  wire        slow,
  input  wire        req,
  input  wire [31:0] addr,
  output reg         vld,
  output reg  [7:0]  data,
  output reg         rdy
);
  reg v;
  initial
  begin
    vld = 1'b0;
    data = 8'h00;
    rdy = 1'b1;
  end
  // idle data is inverted so a stale byte never looks valid
  always @(negedge clk)
  begin
    v = req && (!slow || $urandom_range(1));
    vld <= v;
    data <= v ? addr[7:0] * 8'h03 + 8'h11 : ~data;
    // at most one wait cycle per word, so the writer never falls behind four bytes
    rdy <= !(slow && rdy && $urandom_range(3) == 0);
  end
endmodule // bmseq_rom_model

// ### verif/bmseq_tb_top.sv
// self-checking bench for the boot mode sequencer
`timescale 1ns/10ps
module bmseq_tb_top;
  localparam NB = 16;
  reg         REF_CLK = 0, RST = 1, PCI_SEL_PIN = 0, BIG_ENDIAN_PIN = 0;
  reg  [1:0]  BOOT_MODE_PIN = 0;
  reg         HOST_INT_SET = 0, CPU_INT_CLEAR = 0, slow = 0;
  wire        vld, rdy, stall, prst, hpe, pcie, hmem, hbit, pend, rreq, ce1, wvld, done;
  wire [7:0]  rbyte;
  wire [31:0] start, raddr, waddr, wdata;
  integer     fail_count = 0, n_tests = 0, nwords = 0, i, m;
  always #50 REF_CLK = ~REF_CLK;
  bmseq_top #(.COPY_BYTES(NB)) u_bmseq_top (.REF_CLK(REF_CLK), .RST(RST),
    .BOOT_MODE_PIN(BOOT_MODE_PIN), .PCI_SEL_PIN(PCI_SEL_PIN), .BIG_ENDIAN_PIN(BIG_ENDIAN_PIN),
    .HOST_INT_SET(HOST_INT_SET), .CPU_INT_CLEAR(CPU_INT_CLEAR), .ROM_BYTE_VLD(vld),
    .ROM_BYTE(rbyte), .MEM_WR_READY(rdy), .CPU_STALL(stall), .CPU_START_ADDR(start),
    .PERIPH_RESET(prst), .HOST_PORT_EN(hpe), .PCI_BOOT_EN(pcie), .HOST_MEM_ACCESS_EN(hmem),
    .HOST_INT_BIT(hbit), .CPU_INT_PENDING(pend), .ROM_RD_REQ(rreq), .ROM_RD_ADDR(raddr),
    .ROM_RD_CE1(ce1), .MEM_WR_VLD(wvld), .MEM_WR_ADDR(waddr), .MEM_WR_DATA(wdata),
    .BOOT_DONE(done));
  bmseq_rom_model u_bmseq_rom_model (.clk(REF_CLK), .slow(slow), .req(rreq), .addr(raddr),
    .vld(vld), .data(rbyte), .rdy(rdy));
  function [7:0] rb(input [31:0] a);
    rb = a[7:0] * 8'h03 + 8'h11;
  endfunction
  function [31:0] exp_word(input integer w, input be);
    reg [31:0] a;
    begin
      a = 32'h90000000 + w * 4;
      exp_word = be ? {rb(a), rb(a + 1), rb(a + 2), rb(a + 3)}
                    : {rb(a + 3), rb(a + 2), rb(a + 1), rb(a)};
    end
  endfunction
  task chk_word(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task chk_bit(input got, input exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task print_verdict;
  begin
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task boot(input [1:0] md, input p, input b);
  begin
    @(negedge REF_CLK);
    RST = 1;
    BOOT_MODE_PIN = md;
    PCI_SEL_PIN = p;
    BIG_ENDIAN_PIN = b;
    repeat (6) @(negedge REF_CLK);
    chk_bit(stall & prst, 1);
    chk_bit(wvld | rreq | done, 0);
    RST = 0;
    nwords = 0;
    repeat (9) @(negedge REF_CLK);
  end
  endtask
  task hset;
  begin
    HOST_INT_SET = 1;
    @(negedge REF_CLK);
    HOST_INT_SET = 0;
    repeat (3) @(negedge REF_CLK);
  end
  endtask
  always @(posedge REF_CLK)
    if (wvld && rdy)
    begin
      chk_word(waddr, nwords * 4);
      chk_word(wdata, exp_word(nwords, BIG_ENDIAN_PIN));
      nwords = nwords + 1;
    end
  initial
  begin
    #3000000;
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial
  begin
    i = $urandom(32'h7373);
    for (m = 0; m < 5; m = m + 1)
    begin
      slow = $urandom_range(1);
      // last pass resets in the middle of a copy, then copies again
      if (m == 4)
      begin
        boot(2'h3, 1'b1, 1'b1);
        repeat (12) @(negedge REF_CLK);
      end
      boot((m == 4) ? 2'h3 : m, $urandom_range(1), $urandom_range(1));
      chk_bit(prst, 0);
      if (m == 1)
      begin
        chk_bit(stall, 1);
        chk_bit(hmem, 1);
        chk_bit(pcie, PCI_SEL_PIN);
        chk_bit(hpe, !PCI_SEL_PIN);
        PCI_SEL_PIN = !PCI_SEL_PIN;
        repeat ($urandom_range(20)) @(negedge REF_CLK);
        chk_bit(stall, 1);
        hset;
        chk_bit(stall, 0);
        chk_bit(pend, 0);
        chk_bit(pcie, !PCI_SEL_PIN);
        CPU_INT_CLEAR = 1;
        @(negedge REF_CLK);
        CPU_INT_CLEAR = 0;
        repeat (3) @(negedge REF_CLK);
        chk_bit(hbit, 0);
        hset;
        chk_bit(hbit, 1);
      end
      else if (m >= 3)
      begin
        hset;
        chk_bit(stall, 1);
        for (i = 0; i < 3000 && done !== 1'b1; i = i + 1)
          @(negedge REF_CLK);
        chk_word(nwords, NB / 4);
        chk_bit(stall, 0);
      end
      else
      begin
        hset;
        chk_bit(stall, 0);
        chk_bit(done & !hmem, 1);
        chk_word(nwords, 0);
      end
    end
    print_verdict;
  end
endmodule // bmseq_tb_top
